// *** shared/uart_dce_pkg.sv ***
package uart_dce_pkg;

  // ----------------------------------------------------------------
  // clock and bit rates
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int NUM_RATES = 12;
  localparam int unsigned RATES [NUM_RATES] = '{
    9600, 19200, 38400, 57600, 115200, 230400,
    460800, 921600, 3000000, 3250000, 6000000, 6500000
  };
  localparam logic [3:0] RATE_IDX_DEFAULT = 4'h4;
  // quiet line time, in bit periods, before format recognition arms
  localparam int IDLE_WAIT_BITS = 12;

  // ----------------------------------------------------------------
  // character formats, flow control, power saving
  // ----------------------------------------------------------------
  localparam logic [2:0] FMT_8N2 = 3'h0;
  localparam logic [2:0] FMT_8N1 = 3'h1;
  localparam logic [2:0] FMT_8E1 = 3'h2;
  localparam logic [2:0] FMT_8O1 = 3'h3;
  localparam logic [2:0] FMT_7E1 = 3'h4;
  localparam logic [2:0] FMT_7O1 = 3'h5;
  localparam logic [1:0] FLOW_HW = 2'h0;
  localparam logic [1:0] FLOW_SW = 2'h1;
  localparam logic [1:0] FLOW_NONE = 2'h2;
  localparam logic [1:0] PS_OFF = 2'h0;
  localparam logic [1:0] PS_RTS = 2'h1;
  localparam logic [1:0] PS_DTR = 2'h2;
  localparam logic [7:0] XON_CHAR = 8'h11;
  localparam logic [7:0] XOFF_CHAR = 8'h13;

  // ----------------------------------------------------------------
  // multiplexer framing
  // ----------------------------------------------------------------
  localparam logic [7:0] MUX_FLAG = 8'hf9;
  localparam logic [5:0] MUX_CH_CTRL = 6'h00;
  localparam logic [5:0] MUX_CH_GNSS = 6'h06;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_TXDATA = 12'h008;
  localparam logic [11:0] ADDR_RXDATA = 12'h00c;
  localparam int CTRL_RATE_LSB = 0;
  localparam int CTRL_FMT_LSB = 4;
  localparam int CTRL_FLOW_LSB = 8;
  localparam int CTRL_PS_LSB = 10;
  localparam int CTRL_AUTO_BIT = 12;
  localparam int CTRL_MUX_BIT = 13;
  localparam int CTRL_DSR_BIT = 16;
  localparam int CTRL_DCD_BIT = 17;
  localparam int CTRL_RI_BIT = 18;
  localparam logic [31:0] CTRL_RESET = 32'h0000_1014;
  localparam logic [31:0] CTRL_MASK = 32'h0007_3f7f;
  localparam int ST_RXV = 0;
  localparam int ST_TXR = 1;
  localparam int ST_DONE = 2;
  localparam int ST_CTS = 3;
  localparam int ST_SLEEP = 4;
  localparam int ST_XOFF = 5;
  localparam int ST_PERR = 8;
  localparam int ST_FERR = 9;
  localparam int ST_OVR = 10;
  localparam int ST_MUXERR = 11;
  localparam int ST_RATE_LSB = 12;
  localparam int ST_FMT_LSB = 16;
  localparam int ST_CH_LSB = 20;
  localparam int RXD_VALID_BIT = 8;

  // cycles per bit, rounded to nearest; an unknown index falls back to default
  function automatic logic [15:0] rate_div(input logic [3:0] idx);
    int unsigned r;
    r = (idx < 4'(NUM_RATES)) ? RATES[idx] : RATES[RATE_IDX_DEFAULT];
    return 16'((CLK_HZ + r / 2) / r);
  endfunction : rate_div

endpackage : uart_dce_pkg

// *** logic/buf2.sv ***
`timescale 1ns/1ns
module buf2 #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  logic [WIDTH-1:0] mem [2];
  logic wp, rp;
  logic [1:0] count;
  logic push, pop;

  assign in_ready = count != 2'h2;
  assign out_valid = count != 2'h0;
  assign out_data = mem[rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp <= 1'b0;
      rp <= 1'b0;
      count <= 2'h0;
    end else begin
      if (push) wp <= !wp;
      if (pop) rp <= !rp;
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge clk) begin
    if (push) mem[wp] <= in_data;
  end

  count_bound_a: assert property (@(posedge clk) disable iff (!rst_n) count <= 2'h2)
    else $error("buffer count above two");
  full_ready_a: assert property (@(posedge clk) disable iff (!rst_n) push && !pop && count == 2'h1 |=> !in_ready)
    else $error("buffer full but still ready");

endmodule : buf2

// *** logic/uart_dce.sv ***
// Behaviour
// R1: eight lines: drive rxd, cts, dsr, dcd, ri; take txd, rts, dtr.
// R2: low is a zero bit or ON, high is a one bit or OFF.
// R3: hardware, software or no flow control; hardware after reset.
// R4: clear-to-send goes OFF whenever data cannot be accepted, sleep included.
// R5: power saving may be steered by request-to-send or data-terminal-ready.
// R6: twelve bit rates from 9600 up to 6500000 bit/s.
// R7: without rate detection run at 115200 until a command changes it.
// R8: rate detection on after reset, once only; later only commands change it.
// R9: formats 8N2, 8N1, 8E1, 8O1, 7E1 and 7O1.
// R10: without format recognition use eight data bits, no parity, one stop.
// R11: format recognition on after reset with rate detection, once only.
// R12: multiplexer framing over the link, device as DCE, host as DTE.
// R13: channel 0 control, 1 to 5 sessions, 6 positioning data.
// R14: rate or format changes apply only between characters.
`timescale 1ns/1ns
module uart_dce
  import uart_dce_pkg::*;
(
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial lines, control lines low when ON
  input wire logic txd,
  input wire logic rts_n,
  input wire logic dtr_n,
  output logic rxd,
  output logic cts_n,
  output logic dsr_n,
  output logic dcd_n,
  output logic ri_n
);

  typedef enum logic [1:0] {DET_RATE, DET_FMT, DET_DONE} det_t;
  typedef enum logic [1:0] {RX_IDLE, RX_MEAS, RX_START, RX_BITS} rx_t;

  function automatic logic fmt_db8(input logic [2:0] f);
    return f <= FMT_8O1;
  endfunction : fmt_db8

  function automatic logic fmt_par(input logic [2:0] f);
    return f >= FMT_8E1;
  endfunction : fmt_par

  function automatic logic fmt_odd(input logic [2:0] f);
    return f == FMT_8O1 || f == FMT_7O1;
  endfunction : fmt_odd

  // bits after the start bit
  function automatic logic [3:0] n_after(input logic [2:0] f);
    return (f == FMT_8N2 || f == FMT_8E1 || f == FMT_8O1) ? 4'ha : 4'h9;
  endfunction : n_after

  // nearest rate to a measured start-bit width
  function automatic logic [3:0] pick_rate(input logic [16:0] cnt);
    logic [16:0] best, d, diff;
    pick_rate = RATE_IDX_DEFAULT;
    best = '1;
    for (int i = 0; i < NUM_RATES; i++) begin
      d = {1'b0, rate_div(4'(i))};
      diff = (cnt > d) ? cnt - d : d - cnt;
      if (diff < best) begin
        best = diff;
        pick_rate = 4'(i);
      end
    end
  endfunction : pick_rate

  logic [31:0] ctrl, status;
  logic cfg_pending, apply, sleep, flow_ok, fall, txd_q, fmt_armed, meas_end, fmt_guess;
  logic [3:0] rate_app, pick_idx, rx_idx, tx_left;
  logic [2:0] fmt_app;
  logic [1:0] flow;
  logic [15:0] div, tx_cnt;
  logic [16:0] rx_cnt;
  logic [19:0] quiet_cnt, quiet_lim;
  logic [9:0] rbits;
  logic [11:0] tx_shift, tx_frame;
  logic [7:0] rx_data, tx_out_data, rx_out_data;
  logic par_bad, stop_bad, rx_end, rx_take, rx_push, flowchar, mux_take, flag_seen;
  logic perr, ferr, ovr, muxerr, xoff;
  logic [5:0] mux_ch;
  logic tx_busy, tx_send, tx_in_ready, tx_out_valid, rx_in_ready, rx_out_valid, rx_pop;
  logic setup, access, wr_done, rd_done, mapped, to_ctrl, to_stat, to_tx, to_rx, clr;
  det_t det;
  rx_t rx_st;

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign to_ctrl = paddr == ADDR_CTRL;
  assign to_stat = paddr == ADDR_STATUS;
  assign to_tx = paddr == ADDR_TXDATA;
  assign to_rx = paddr == ADDR_RXDATA;
  assign mapped = to_ctrl || to_stat || to_tx || to_rx;
  // a full transmit buffer stalls the bus instead of dropping the word
  assign pready = !(access && pwrite && to_tx && !tx_in_ready);
  assign pslverr = access && !mapped;
  assign wr_done = access && pwrite && pready && mapped;
  assign rd_done = access && !pwrite && mapped;
  assign clr = wr_done && to_stat;
  // pop only what the setup cycle saw, so no byte is lost unseen
  assign rx_pop = rd_done && to_rx && prdata[RXD_VALID_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      case (1'b1)
        to_ctrl: prdata <= ctrl;
        to_stat: prdata <= status;
        to_rx: prdata <= {23'h000000, rx_out_valid, rx_out_data};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RESET; // R3 R8 R11
    end else if (wr_done && to_ctrl) begin
      ctrl <= pwdata & CTRL_MASK;
    end
  end

  always_comb begin
    status = 32'h0000_0000;
    status[ST_RXV] = rx_out_valid;
    status[ST_TXR] = tx_in_ready;
    status[ST_DONE] = det == DET_DONE;
    status[ST_CTS] = !cts_n;
    status[ST_SLEEP] = sleep;
    status[ST_XOFF] = xoff;
    status[ST_PERR] = perr;
    status[ST_FERR] = ferr;
    status[ST_OVR] = ovr;
    status[ST_MUXERR] = muxerr;
    status[ST_RATE_LSB +: 4] = rate_app;
    status[ST_FMT_LSB +: 3] = fmt_app;
    status[ST_CH_LSB +: 6] = mux_ch;
  end

  // ----------------------------------------------------------------
  // configuration and start-up detection
  // ----------------------------------------------------------------
  assign flow = ctrl[CTRL_FLOW_LSB +: 2];
  assign div = rate_div(rate_app); // R6
  assign sleep = (ctrl[CTRL_PS_LSB +: 2] == PS_RTS && rts_n) || (ctrl[CTRL_PS_LSB +: 2] == PS_DTR && dtr_n); // R5
  assign apply = cfg_pending && det == DET_DONE && rx_st == RX_IDLE && !fall && !tx_busy; // R14
  assign meas_end = rx_st == RX_MEAS && txd;
  assign pick_idx = pick_rate(rx_cnt);
  assign fmt_guess = rbits[7];
  assign quiet_lim = 20'(div) * 20'(IDLE_WAIT_BITS);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_pending <= 1'b0;
    end else if (wr_done && to_ctrl) begin
      cfg_pending <= 1'b1;
    end else if (apply) begin
      cfg_pending <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_app <= RATE_IDX_DEFAULT; // R7
      fmt_app <= FMT_8N1; // R10
    end else if (det == DET_RATE && meas_end && ctrl[CTRL_AUTO_BIT]) begin
      rate_app <= pick_idx; // R8
    end else if (det == DET_FMT && rx_end && ctrl[CTRL_AUTO_BIT]) begin
      // the second character is taken as a capital letter: bit 7 set means 7E1
      fmt_app <= fmt_guess ? FMT_7E1 : FMT_8N1; // R11
    end else if (apply) begin
      rate_app <= ctrl[CTRL_RATE_LSB +: 4];
      fmt_app <= ctrl[CTRL_FMT_LSB +: 3];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      det <= DET_RATE;
    end else begin
      case (det)
        DET_RATE: if (!ctrl[CTRL_AUTO_BIT]) det <= DET_DONE; else if (meas_end) det <= DET_FMT;
        DET_FMT: if (!ctrl[CTRL_AUTO_BIT] || rx_end) det <= DET_DONE;
        DET_DONE: det <= DET_DONE; // R8 R11
        default: det <= DET_DONE;
      endcase
    end
  end

  // the rest of the first character must pass before format sampling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quiet_cnt <= 20'h00000;
      fmt_armed <= 1'b0;
    end else begin
      if (!txd) quiet_cnt <= 20'h00000;
      else if (quiet_cnt != 20'hfffff) quiet_cnt <= quiet_cnt + 20'h00001;
      if (det == DET_FMT && quiet_cnt >= quiet_lim) fmt_armed <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // receiver on txd
  // ----------------------------------------------------------------
  assign fall = txd_q && !txd; // R2
  assign rx_data = fmt_db8(fmt_app) ? rbits[7:0] : {1'b0, rbits[6:0]}; // R9
  assign par_bad = fmt_par(fmt_app) && ((fmt_db8(fmt_app) ? rbits[8] : rbits[7]) != (^rx_data ^ fmt_odd(fmt_app)));
  assign stop_bad = !rbits[(fmt_db8(fmt_app) && fmt_par(fmt_app)) ? 9 : 8] || (fmt_app == FMT_8N2 && !rbits[9]);
  assign rx_take = rx_end && det == DET_DONE;
  assign flowchar = flow == FLOW_SW && (rx_data == XON_CHAR || rx_data == XOFF_CHAR);
  assign rx_push = rx_take && !par_bad && !stop_bad && !flowchar;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txd_q <= 1'b1;
      rx_st <= RX_IDLE;
      rx_cnt <= 17'h00000;
      rx_idx <= 4'h0;
      rbits <= 10'h3ff;
      rx_end <= 1'b0;
    end else begin
      txd_q <= txd;
      rx_end <= 1'b0;
      case (rx_st)
        RX_IDLE: begin
          rx_cnt <= 17'h00000;
          if (fall && det == DET_RATE && ctrl[CTRL_AUTO_BIT]) rx_st <= RX_MEAS;
          else if (fall && (det == DET_DONE || (det == DET_FMT && fmt_armed))) rx_st <= RX_START;
        end
        RX_MEAS: begin
          if (txd) rx_st <= RX_IDLE;
          else if (rx_cnt != 17'h1ffff) rx_cnt <= rx_cnt + 17'h00001;
        end
        RX_START: begin
          if (rx_cnt == {2'b00, div[15:1]}) begin
            rx_st <= txd ? RX_IDLE : RX_BITS;
            rx_cnt <= 17'h00000;
            rx_idx <= 4'h0;
          end else begin
            rx_cnt <= rx_cnt + 17'h00001;
          end
        end
        RX_BITS: begin
          if (rx_cnt == {1'b0, div} - 17'h00001) begin
            rx_cnt <= 17'h00000;
            rbits[rx_idx] <= txd;
            rx_idx <= rx_idx + 4'h1;
            if (rx_idx == n_after(fmt_app) - 4'h1) begin
              rx_st <= RX_IDLE;
              rx_end <= 1'b1;
            end
          end else begin
            rx_cnt <= rx_cnt + 17'h00001;
          end
        end
        default: rx_st <= RX_IDLE;
      endcase
    end
  end

  // errors are sticky; write one to clear, a new event wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      perr <= 1'b0;
      ferr <= 1'b0;
      ovr <= 1'b0;
      muxerr <= 1'b0;
    end else begin
      perr <= (rx_take && par_bad) || (perr && !(clr && pwdata[ST_PERR]));
      ferr <= (rx_take && stop_bad) || (ferr && !(clr && pwdata[ST_FERR]));
      ovr <= (rx_push && !rx_in_ready) || (ovr && !(clr && pwdata[ST_OVR]));
      muxerr <= (mux_take && flag_seen && rx_data != MUX_FLAG && rx_data[7:2] > MUX_CH_GNSS) ||
                (muxerr && !(clr && pwdata[ST_MUXERR])); // R13
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xoff <= 1'b0;
    end else if (flow != FLOW_SW) begin
      xoff <= 1'b0;
    end else if (rx_take && !par_bad && !stop_bad && flowchar) begin
      xoff <= rx_data == XOFF_CHAR; // R3
    end
  end

  // ----------------------------------------------------------------
  // multiplexer address tracking
  // ----------------------------------------------------------------
  assign mux_take = rx_push && rx_in_ready && ctrl[CTRL_MUX_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_seen <= 1'b0;
      mux_ch <= MUX_CH_CTRL;
    end else if (mux_take) begin
      // repeated flags keep waiting; the octet after a flag is the address
      if (rx_data == MUX_FLAG) begin
        flag_seen <= 1'b1;
      end else if (flag_seen) begin
        mux_ch <= rx_data[7:2]; // R12
        flag_seen <= 1'b0;
      end
    end
  end

  buf2 #(.WIDTH(8)) rx_buf (
    .clk(pclk),
    .rst_n(presetn),
    .in_valid(rx_push),
    .in_ready(rx_in_ready),
    .in_data(rx_data),
    .out_valid(rx_out_valid),
    .out_ready(rx_pop),
    .out_data(rx_out_data)
  );

  // ----------------------------------------------------------------
  // transmitter on rxd
  // ----------------------------------------------------------------
  assign flow_ok = (flow == FLOW_HW) ? !rts_n : ((flow == FLOW_SW) ? !xoff : 1'b1); // R3
  assign tx_send = tx_out_valid && !tx_busy && !apply && flow_ok; // R14

  always_comb begin
    if (fmt_db8(fmt_app)) begin
      tx_frame = {2'b11, fmt_par(fmt_app) ? (^tx_out_data ^ fmt_odd(fmt_app)) : 1'b1, tx_out_data, 1'b0}; // R9
    end else begin
      tx_frame = {3'b111, ^tx_out_data[6:0] ^ fmt_odd(fmt_app), tx_out_data[6:0], 1'b0};
    end
  end

  buf2 #(.WIDTH(8)) tx_buf (
    .clk(pclk),
    .rst_n(presetn),
    .in_valid(wr_done && to_tx),
    .in_ready(tx_in_ready),
    .in_data(pwdata[7:0]),
    .out_valid(tx_out_valid),
    .out_ready(tx_send),
    .out_data(tx_out_data)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_busy <= 1'b0;
      rxd <= 1'b1;
      tx_shift <= 12'hfff;
      tx_left <= 4'h0;
      tx_cnt <= 16'h0000;
    end else if (tx_send) begin
      tx_busy <= 1'b1;
      rxd <= 1'b0;
      tx_shift <= tx_frame;
      tx_left <= n_after(fmt_app) + 4'h1;
      tx_cnt <= 16'h0000;
    end else if (tx_busy) begin
      if (tx_cnt == div - 16'h0001) begin
        tx_cnt <= 16'h0000;
        tx_shift <= {1'b1, tx_shift[11:1]};
        tx_left <= tx_left - 4'h1;
        rxd <= (tx_left == 4'h1) ? 1'b1 : tx_shift[1]; // R2
        if (tx_left == 4'h1) tx_busy <= 1'b0;
      end else begin
        tx_cnt <= tx_cnt + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // modem control outputs
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cts_n <= 1'b1;
      dsr_n <= 1'b1;
      dcd_n <= 1'b1;
      ri_n <= 1'b1;
    end else begin
      cts_n <= !(rx_in_ready && !sleep); // R4
      dsr_n <= !ctrl[CTRL_DSR_BIT]; // R1
      dcd_n <= !ctrl[CTRL_DCD_BIT];
      ri_n <= !ctrl[CTRL_RI_BIT];
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence meas_done_s;
    det == DET_RATE && meas_end && ctrl[CTRL_AUTO_BIT];
  endsequence
  sequence fmt_done_s;
    det == DET_FMT && rx_end && ctrl[CTRL_AUTO_BIT];
  endsequence

  auto_rate_a: assert property (meas_done_s |=> det == DET_FMT && rate_app == $past(pick_idx)) // R8
    else $error("detected rate not applied");
  auto_fmt_a: assert property (fmt_done_s |=> det == DET_DONE && fmt_app == ($past(fmt_guess) ? FMT_7E1 : FMT_8N1)) // R11
    else $error("detected format not applied");
  det_once_a: assert property (det == DET_DONE |=> det == DET_DONE) // R8
    else $error("detection ran again");
  reset_cfg_a: assert property (det == DET_RATE |-> rate_app == RATE_IDX_DEFAULT && fmt_app == FMT_8N1) // R7
    else $error("default rate or format lost");
  cts_off_a: assert property (sleep || !rx_in_ready |=> cts_n) // R4
    else $error("cts on while unable to accept");
  hw_hold_a: assert property (flow == FLOW_HW && rts_n && !tx_busy |=> !tx_busy) // R3
    else $error("sent while rts off");
  sw_hold_a: assert property (flow == FLOW_SW && xoff && !tx_busy |=> !tx_busy) // R3
    else $error("sent while paused by xoff");
  cfg_stable_a: assert property (tx_busy || (rx_st != RX_IDLE && det == DET_DONE) |=> // R14
    $stable(rate_app) && $stable(fmt_app))
    else $error("configuration changed mid character");
  line_idle_a: assert property (!tx_busy |-> rxd) // R2
    else $error("rxd not idle high");
  tx_start_a: assert property ($rose(tx_busy) |-> !rxd ##1 tx_busy && !rxd) // R1
    else $error("start bit missing");
  mux_addr_a: assert property (mux_take && flag_seen && rx_data != MUX_FLAG |=> // R12
    mux_ch == $past(rx_data[7:2]) && !flag_seen)
    else $error("channel address not captured");

endmodule : uart_dce

// *** testbench/host_dte.sv ***
`timescale 1ns/1ns
module host_dte (
  // clock
  input wire logic clk,
  // serial lines seen from the host
  input wire logic rxd,
  output logic txd,
  output logic rts_n,
  output logic dtr_n
);
  // --------------------------------
  // line driving, low is zero or ON
  // --------------------------------
  initial begin
    txd = 1'b1;
    rts_n = 1'b1;
    dtr_n = 1'b0;
  end

  task automatic lines(input logic r, input logic d);
    rts_n <= r;
    dtr_n <= d;
  endtask : lines

  // one 8N1 character; the host does not look at cts here, so it can overrun on purpose
  task automatic send(input int div, input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      txd <= fr[i];
      repeat (div) @(posedge clk);
    end
  endtask : send

  // mid-bit sampling, lsb first; nb counts data, parity and first stop
  task automatic recv(input int div, input int nb, output logic [9:0] d);
    d = '0;
    while (rxd !== 1'b0) @(posedge clk);
    repeat (div / 2) @(posedge clk);
    for (int i = 0; i < nb; i++) begin
      repeat (div) @(posedge clk);
      d[i] = rxd;
    end
  endtask : recv
endmodule : host_dte

// *** testbench/tb_modem_uart_autobaud_mux.sv ***
`timescale 1ns/1ns
module tb_modem_uart_autobaud_mux
  import uart_dce_pkg::*;
;
  `define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin fail_count++; $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, err, txd, rts_n, dtr_n, rxd, cts_n, dsr_n, dcd_n, ri_n, p;
  logic [9:0] f, ex;
  logic [7:0] b;
  int fail_count = 0;
  int samples_checked = 0;
  int dv, k;

  always #25 pclk = ~pclk;

  uart_dce i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .txd(txd),
    .rts_n(rts_n), .dtr_n(dtr_n), .rxd(rxd), .cts_n(cts_n), .dsr_n(dsr_n), .dcd_n(dcd_n), .ri_n(ri_n));
  host_dte i_host (.clk(pclk), .rxd(rxd), .txd(txd), .rts_n(rts_n), .dtr_n(dtr_n));

  // --------------------------------
  // apb master
  // --------------------------------
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no own limit: a stalled slave is caught by the watchdog
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer

  task automatic results;
    if (fail_count == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results

  initial begin
    repeat (100000) @(posedge pclk);
    fail_count++;
    results();
  end

  // --------------------------------
  // tests
  // --------------------------------
  initial begin
    repeat (10) @(posedge pclk);
    `CHK({cts_n, dsr_n, dcd_n, ri_n, rxd}, 5'h1f)
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    `CHK(cts_n, 1'b0)
    xfer(1'b0, ADDR_CTRL, 32'h0);
    `CHK(q, CTRL_RESET)
    // detection off, status lines ON, 115200 8N1, hw flow
    xfer(1'b1, ADDR_CTRL, 32'h0007_0014);
    xfer(1'b0, ADDR_STATUS, 32'h0);
    `CHK(q[18:12], 7'h14)
    `CHK({dsr_n, dcd_n, ri_n}, 3'h0)
    // rts OFF stalls the transmitter with both buffer slots full
    xfer(1'b1, ADDR_TXDATA, 32'h5a);
    xfer(1'b1, ADDR_TXDATA, 32'hc3);
    repeat (2000) @(posedge pclk);
    `CHK(rxd, 1'b1)
    i_host.lines(1'b0, 1'b0);
    i_host.recv(174, 9, f);
    `CHK(f, 10'h15a)
    i_host.recv(174, 9, f);
    `CHK(f, 10'h1c3)
    for (int i = 0; i < NUM_RATES; i++) begin
      dv = (CLK_HZ + RATES[i] / 2) / RATES[i];
      k = i % 6;
      b = 8'h5a ^ 8'(i);
      p = (k >= 4 ? ^b[6:0] : ^b) ^ k[0];
      ex = k < 2 ? {2'b01, b} : k < 4 ? {1'b1, p, b} : {2'b01, p, b[6:0]};
      xfer(1'b1, ADDR_CTRL, {25'h0, 3'(k), 4'(i)});
      xfer(1'b1, ADDR_TXDATA, {24'h0, b});
      i_host.recv(dv, (k == 2 || k == 3) ? 10 : 9, f);
      `CHK(f, ex)
      repeat (3 * dv) @(posedge pclk);
    end
    for (int j = 1; j < 3; j++) begin
      xfer(1'b1, ADDR_CTRL, 32'h14 | j << 10);
      i_host.lines(j == 1, j == 2);
      repeat (4) @(posedge pclk);
      `CHK(cts_n, 1'b1)
      i_host.lines(1'b0, 1'b0);
      repeat (4) @(posedge pclk);
      `CHK(cts_n, 1'b0)
    end
    // mux tracking; the receive buffer is filled, overrun, then drained
    xfer(1'b1, ADDR_CTRL, 32'h0000_2014);
    i_host.send(174, MUX_FLAG);
    i_host.send(174, 8'h1b);
    repeat (8) @(posedge pclk);
    `CHK(cts_n, 1'b1)
    xfer(1'b0, ADDR_STATUS, 32'h0);
    `CHK(q[25:20], MUX_CH_GNSS)
    i_host.send(174, 8'h42);
    repeat (8) @(posedge pclk);
    xfer(1'b0, ADDR_STATUS, 32'h0);
    `CHK(q[ST_OVR], 1'b1)
    xfer(1'b0, ADDR_RXDATA, 32'h0);
    `CHK(q[8:0], 9'h1f9)
    xfer(1'b0, ADDR_RXDATA, 32'h0);
    `CHK(q[8:0], 9'h11b)
    xfer(1'b0, ADDR_RXDATA, 32'h0);
    `CHK(q[8], 1'b0)
    xfer(1'b1, ADDR_STATUS, 32'h400);
    xfer(1'b0, ADDR_STATUS, 32'h0);
    `CHK(q[ST_OVR], 1'b0)
    xfer(1'b0, 12'h010, 32'h0);
    `CHK({err, q}, 33'h1_0000_0000)
    // software flow: xoff holds a queued byte, xon releases it
    xfer(1'b1, ADDR_CTRL, 32'h0000_0114);
    i_host.send(174, XOFF_CHAR);
    xfer(1'b1, ADDR_TXDATA, 32'h33);
    repeat (400) @(posedge pclk);
    xfer(1'b0, ADDR_STATUS, 32'h0);
    `CHK({rxd, q[ST_XOFF], q[ST_RXV]}, 3'h6)
    // the byte leaves before xon ends, so the receiver must already wait
    fork
      i_host.send(174, XON_CHAR);
      i_host.recv(174, 9, f);
    join
    `CHK(f, 10'h133)
    // second reset: one-shot detection of rate and format
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    `CHK({cts_n, rxd}, 2'h3)
    presetn <= 1'b1;
    @(posedge pclk);
    i_host.send(87, 8'h41);
    repeat (1131) @(posedge pclk);
    i_host.send(87, 8'hd4);
    xfer(1'b0, ADDR_STATUS, 32'h0);
    `CHK({q[18:12], q[ST_DONE], q[ST_RXV]}, 9'h116)
    xfer(1'b1, ADDR_TXDATA, 32'h54);
    i_host.recv(87, 9, f);
    `CHK(f, 10'h1d4)
    results();
  end
endmodule : tb_modem_uart_autobaud_mux
